//--- hw/qid_pkg.sv
package qid_pkg;
   localparam int TAPS       = 41;
   localparam int HALF_TAPS  = 20;
   localparam int UPSAMPLE   = 4;
   localparam int POLY_LEN   = 11;
   localparam int CIC_STAGES = 4;
   localparam int DIFF_DELAY = 1;
   localparam int R1_MIN     = 3;
   localparam int R1_MAX     = 31;
   localparam int R2_MIN     = 2;
   localparam int R2_MAX     = 63;
   localparam int R1_W       = 5;
   localparam int R2_W       = 6;
   localparam int REF_MULT   = 6;
   localparam int SYM_W      = 3;
   localparam int FIR_W      = 13;
   localparam int OUT_W      = 10;
   localparam int BUF_DEPTH  = 2;
   localparam int BITS_QPSK  = 2;
   localparam int BITS_QAM16 = 4;
   localparam int PER_W      = 4;
   // Half of the symmetric pulse-shaping response, centre tap first.
   localparam logic signed [9:0] COEF_HALF [0:HALF_TAPS] = '{
      10'sh1FF, 10'sh1EF, 10'sh1C1, 10'sh17D, 10'sh12A, 10'sh0D3, 10'sh081,
      10'sh03C, 10'sh009, -10'sh016, -10'sh024, -10'sh024, -10'sh01B,
      -10'sh00E, -10'sh002, 10'sh006, 10'sh009, 10'sh008, 10'sh005,
      10'sh001, -10'sh001};
   localparam logic [1:0]       PHASE_RST = 2'h0;
   localparam logic [1:0]       PHASE_LAST = 2'h3;
   localparam logic signed [2:0] LVL_P3 = 3'sh3;
   localparam logic signed [2:0] LVL_P1 = 3'sh1;
   localparam logic signed [2:0] LVL_M1 = -3'sh1;
   localparam logic signed [2:0] LVL_M3 = -3'sh3;
endpackage

//--- hw/qid_cic.sv
`timescale 1ns/10ps
module qid_cic #(
   parameter int W  = 13,
   parameter int RW = 5,
   parameter int OW = 13
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 in_en,
   input  wire logic                 out_en,
   input  wire logic [RW-1:0]        rate,
   input  wire logic signed [W-1:0]  din,
   output logic signed [OW-1:0]      dout
);
   localparam int N  = qid_pkg::CIC_STAGES;
   localparam int AW = W + N * RW;

   logic signed [AW-1:0] cx [0:N];
   logic signed [AW-1:0] ix [0:N];
   logic signed [AW-1:0] dly_reg [0:N-1];
   logic [N*RW-1:0]      rate_pow;
   logic [7:0]           shift;
   logic signed [AW-1:0] scaled;

   function automatic logic [7:0] ceil_log2(input logic [N*RW-1:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < N * RW; i++) begin
         if ((v - 1'b1) >> i != '0) begin
            r = 8'(i + 1);
         end
      end
      return r;
   endfunction

   assign cx[0] = AW'(din);
   // Zero-stuffing: the comb output enters only on input-rate ticks.
   assign ix[0] = in_en ? cx[N] : '0;
   // Gain R^N over the integrators is divided down by its power-of-two ceiling.
   assign rate_pow = (N*RW)'(rate) * (N*RW)'(rate) * (N*RW)'(rate) * (N*RW)'(rate);
   assign shift    = ceil_log2(rate_pow);
   assign scaled   = ix[N] >>> shift;

   genvar k;
   generate
      for (k = 0; k < N; k++) begin : g_stage
         logic signed [AW-1:0] acc_reg;
         assign cx[k+1] = cx[k] - dly_reg[k];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               dly_reg[k] <= '0;
            end else if (in_en) begin
               dly_reg[k] <= cx[k];
            end
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               acc_reg <= '0;
            end else if (out_en) begin
               acc_reg <= acc_reg + ix[k];
            end
         end
         assign ix[k+1] = acc_reg;
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= '0;
      end else if (out_en) begin
         dout <= scaled[W-1 -: OW];
      end
   end

   comb_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !in_en |=> $stable(dly_reg[0]))
      else $error("comb delay moved without an input tick");
   out_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !out_en |=> $stable(dout))
      else $error("interpolator output moved without an output tick");
endmodule

//--- hw/qid_datapath.sv
`timescale 1ns/10ps
// Summary of operation
// - FIR gives four samples per symbol
// - Symmetric 41-tap pulse-shaping response
// - Ten-bit signed coefficients, peak 511
// - Each CIC: four combs, four integrators
// - Comb differential delay is one sample
// - Interpolators reach the system clock rate
// - CIC stages suppress FIR images
// - 16-QAM gathers four bits per symbol
// - Multiplier gives system clock six times reference
// - CIC gain depends on programmed rate
// - First interpolator rate 3 to 31
// - Second interpolator rate 2 to 63
// - QPSK forms one symbol per two bits
module qid_datapath #(
   parameter int R1_W = qid_pkg::R1_W,
   parameter int R2_W = qid_pkg::R2_W
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              qam16_mode,
   input  wire logic [R1_W-1:0]   rate1,
   input  wire logic [R2_W-1:0]   rate2,
   input  wire logic              bit_data,
   input  wire logic              bit_valid,
   output logic                   bit_ready,
   input  wire logic              multiplier_engaged,
   input  wire logic              reference_clock_input,
   output logic                   ref_ratio_ok,
   output logic                   symbol_underrun,
   output logic signed [9:0]      i_out,
   output logic signed [9:0]      q_out
);
   localparam int L = qid_pkg::POLY_LEN;
   localparam int FW = qid_pkg::FIR_W;

   logic [R1_W-1:0] r1_eff;
   logic [R2_W-1:0] r2_eff;
   logic [R1_W-1:0] cnt1_reg;
   logic [R2_W-1:0] cnt2_reg;
   logic [1:0]      phase_reg;
   logic            en2;
   logic            en1;
   logic            en0;
   logic [1:0]      buf_cnt_reg;
   logic            buf0_reg;
   logic            buf1_reg;
   logic            pop;
   logic            push;
   logic [3:0]      sh_reg;
   logic [2:0]      nbits_reg;
   logic [2:0]      bits_per_sym;
   logic            sym_full_reg;
   logic [3:0]      sym_reg;
   logic [3:0]      sh_next;
   logic signed [2:0] sym_i;
   logic signed [2:0] sym_q;
   logic signed [2:0] di_reg [0:L-1];
   logic signed [2:0] dq_reg [0:L-1];
   logic signed [15:0] sum_i;
   logic signed [15:0] sum_q;
   logic signed [FW-1:0] fir_i_reg;
   logic signed [FW-1:0] fir_q_reg;
   logic signed [FW-1:0] c1_i;
   logic signed [FW-1:0] c1_q;
   logic            under_reg;
   logic            ref_s1_reg;
   logic            ref_s2_reg;
   logic            ref_s3_reg;
   logic            ref_rise;
   logic [qid_pkg::PER_W-1:0] per_reg;
   logic            ratio_reg;

   function automatic logic signed [9:0] coef(input int idx);
      return qid_pkg::COEF_HALF[idx <= qid_pkg::HALF_TAPS ? qid_pkg::HALF_TAPS - idx
                                                         : idx - qid_pkg::HALF_TAPS];
   endfunction

   function automatic logic signed [2:0] level(input logic [1:0] b);
      unique case (b)
         2'h0: return qid_pkg::LVL_M3;
         2'h1: return qid_pkg::LVL_M1;
         2'h3: return qid_pkg::LVL_P1;
         2'h2: return qid_pkg::LVL_P3;
      endcase
   endfunction

   // Out-of-range rates are clamped so the enable chain never stalls.
   assign r1_eff = (rate1 < R1_W'(qid_pkg::R1_MIN)) ? R1_W'(qid_pkg::R1_MIN) : rate1;
   assign r2_eff = (rate2 < R2_W'(qid_pkg::R2_MIN)) ? R2_W'(qid_pkg::R2_MIN) : rate2;
   assign en2 = (cnt2_reg >= r2_eff - 1'b1);
   assign en1 = en2 && (cnt1_reg >= r1_eff - 1'b1);
   assign en0 = en1 && (phase_reg == qid_pkg::PHASE_LAST);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt2_reg  <= '0;
         cnt1_reg  <= '0;
         phase_reg <= qid_pkg::PHASE_RST;
      end else begin
         cnt2_reg <= en2 ? '0 : cnt2_reg + 1'b1;
         if (en2) begin
            cnt1_reg <= en1 ? '0 : cnt1_reg + 1'b1;
         end
         if (en1) begin
            phase_reg <= phase_reg + 1'b1;
         end
      end
   end

   // Two-entry bit buffer; the symbol gatherer drains it only while assembling.
   assign bit_ready = (buf_cnt_reg < 2'(qid_pkg::BUF_DEPTH));
   assign push      = bit_valid && bit_ready;
   assign pop       = (buf_cnt_reg != 2'h0) && !sym_full_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_cnt_reg <= '0;
         buf0_reg    <= 1'b0;
         buf1_reg    <= 1'b0;
      end else begin
         buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
         if (pop) begin
            buf0_reg <= (buf_cnt_reg == 2'h2) ? buf1_reg : bit_data;
         end else if (push && buf_cnt_reg == 2'h0) begin
            buf0_reg <= bit_data;
         end
         if (push && (buf_cnt_reg - {1'b0, pop}) == 2'h1) begin
            buf1_reg <= bit_data;
         end
      end
   end

   assign bits_per_sym = qam16_mode ? 3'(qid_pkg::BITS_QAM16) : 3'(qid_pkg::BITS_QPSK);
   assign sh_next      = {sh_reg[2:0], buf0_reg};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_reg       <= '0;
         nbits_reg    <= '0;
         sym_full_reg <= 1'b0;
         sym_reg      <= '0;
      end else begin
         if (pop) begin
            sh_reg <= sh_next;
            if (nbits_reg + 1'b1 >= bits_per_sym) begin
               nbits_reg    <= '0;
               sym_full_reg <= 1'b1;
               sym_reg      <= sh_next;
            end else begin
               nbits_reg <= nbits_reg + 1'b1;
            end
         end else if (en0) begin
            sym_full_reg <= 1'b0;
         end
      end
   end

   // A missing symbol is sent as zero so the sample timing never slips.
   assign sym_i = !sym_full_reg ? 3'sh0 : qam16_mode ? level(sym_reg[3:2])
                : (sym_reg[1] ? qid_pkg::LVL_M3 : qid_pkg::LVL_P3);
   assign sym_q = !sym_full_reg ? 3'sh0 : qam16_mode ? level(sym_reg[1:0])
                : (sym_reg[0] ? qid_pkg::LVL_M3 : qid_pkg::LVL_P3);

   genvar j;
   generate
      for (j = 0; j < L; j++) begin : g_line
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               di_reg[j] <= '0;
               dq_reg[j] <= '0;
            end else if (en0) begin
               di_reg[j] <= (j == 0) ? sym_i : di_reg[j == 0 ? 0 : j - 1];
               dq_reg[j] <= (j == 0) ? sym_q : dq_reg[j == 0 ? 0 : j - 1];
            end
         end
      end
   endgenerate

   // Polyphase form: each output phase uses every fourth tap of the response.
   always_comb begin
      sum_i = '0;
      sum_q = '0;
      for (int t = 0; t < L; t++) begin
         if (t * qid_pkg::UPSAMPLE + int'(phase_reg) < qid_pkg::TAPS) begin
            // Operands are widened first so the product cannot wrap at ten bits.
            sum_i = sum_i + 16'(di_reg[t]) * 16'(coef(t * qid_pkg::UPSAMPLE + int'(phase_reg)));
            sum_q = sum_q + 16'(dq_reg[t]) * 16'(coef(t * qid_pkg::UPSAMPLE + int'(phase_reg)));
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fir_i_reg <= '0;
         fir_q_reg <= '0;
         under_reg <= 1'b0;
      end else begin
         if (en1) begin
            fir_i_reg <= sum_i[FW:1];
            fir_q_reg <= sum_q[FW:1];
         end
         if (en0) begin
            under_reg <= !sym_full_reg;
         end
      end
   end
   assign symbol_underrun = under_reg;

   qid_cic #(.W(FW), .RW(R1_W), .OW(FW)) u_cic1_i (
      .clk(clk), .rst_n(rst_n), .in_en(en1), .out_en(en2), .rate(r1_eff),
      .din(fir_i_reg), .dout(c1_i));
   qid_cic #(.W(FW), .RW(R1_W), .OW(FW)) u_cic1_q (
      .clk(clk), .rst_n(rst_n), .in_en(en1), .out_en(en2), .rate(r1_eff),
      .din(fir_q_reg), .dout(c1_q));
   qid_cic #(.W(FW), .RW(R2_W), .OW(qid_pkg::OUT_W)) u_cic2_i (
      .clk(clk), .rst_n(rst_n), .in_en(en2), .out_en(1'b1), .rate(r2_eff),
      .din(c1_i), .dout(i_out));
   qid_cic #(.W(FW), .RW(R2_W), .OW(qid_pkg::OUT_W)) u_cic2_q (
      .clk(clk), .rst_n(rst_n), .in_en(en2), .out_en(1'b1), .rate(r2_eff),
      .din(c1_q), .dout(q_out));

   // Reference is a pin: two flops before anything looks at it.
   assign ref_rise = ref_s2_reg && !ref_s3_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_s1_reg <= 1'b0;
         ref_s2_reg <= 1'b0;
         ref_s3_reg <= 1'b0;
         per_reg    <= '0;
         ratio_reg  <= 1'b0;
      end else begin
         ref_s1_reg <= reference_clock_input;
         ref_s2_reg <= ref_s1_reg;
         ref_s3_reg <= ref_s2_reg;
         if (ref_rise) begin
            per_reg   <= '0;
            ratio_reg <= (per_reg == qid_pkg::PER_W'(qid_pkg::REF_MULT - 1));
         end else if (per_reg != '1) begin
            per_reg <= per_reg + 1'b1;
         end
      end
   end
   assign ref_ratio_ok = ratio_reg && multiplier_engaged;

   phase_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
      en1 && phase_reg == 2'h3 |=> phase_reg == 2'h0 && !sym_full_reg || phase_reg == 2'h0)
      else $error("phase did not wrap after fourth sample");
   sym_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
      en0 |=> !en0 [*8])
      else $error("symbol ticks too close together");
   r1_range_a: assert property (@(posedge clk) disable iff (!rst_n)
      en1 |-> r1_eff >= 5'h03 && r1_eff <= 5'h1F)
      else $error("first rate outside range");
   r2_range_a: assert property (@(posedge clk) disable iff (!rst_n)
      en2 |-> r2_eff >= 6'h02 && r2_eff <= 6'h3F)
      else $error("second rate outside range");
   qpsk_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
      !qam16_mode && $rose(sym_full_reg) |-> $past(nbits_reg) == 3'h1)
      else $error("qpsk symbol not two bits");
   qam_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
      qam16_mode && $rose(sym_full_reg) |-> $past(nbits_reg) == 3'h3)
      else $error("qam symbol not four bits");
   fir_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !en1 |=> $stable(fir_i_reg) && $stable(fir_q_reg))
      else $error("fir output moved off its tick");
   ratio_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
      ref_rise && per_reg == 4'h5 |=> ratio_reg)
      else $error("six-clock reference period not flagged");
   buf_full_a: assert property (@(posedge clk) disable iff (!rst_n)
      buf_cnt_reg == 2'h2 |-> !bit_ready)
      else $error("buffer accepts while full");
endmodule

//--- verif/qid_bit_source.sv
`timescale 1ns/10ps
module qid_bit_source (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic       rnd_bits,
   input  wire logic [3:0] pattern,
   input  wire logic [2:0] plen,
   input  wire logic       bit_ready,
   output logic            bit_valid,
   output logic            bit_data,
   output int              accepted
);
   int   seed;
   int   pos;
   logic take;
   int   rv;
   logic nv;
   logic nd;
   // Ready is sampled on the falling edge, so a buffer update at the rising edge cannot race it.
   initial begin
      seed = 92123;
      pos = 0;
      accepted = 0;
      bit_valid = 1'b0;
      bit_data = 1'b0;
      forever begin
         @(negedge clk);
         take = bit_valid && bit_ready;
         @(posedge clk);
         #2;
         if (!rst_n) begin
            bit_valid = 1'b0;
            pos = 0;
            accepted = 0;
         end else begin
            // Next values are worked out first so each pin is written once per step.
            nv = bit_valid;
            nd = bit_data;
            if (take) begin
               accepted++;
               pos++;
               nv = 1'b0;
               nd = ~bit_data;
            end
            if (!nv && run && (!rnd_bits || ($random(seed) % 4 != 0))) begin
               rv = $random(seed);
               nv = 1'b1;
               nd = rnd_bits ? rv[0] : pattern[plen - 1 - (pos % plen)];
            end
            bit_valid = nv;
            bit_data = nd;
         end
      end
   end
endmodule

//--- verif/qid_datapath_test.sv
`timescale 1ns/10ps
module qid_datapath_test;
   logic              clk;
   logic              rst_n;
   logic              qam16_mode;
   logic [4:0]        rate1;
   logic [5:0]        rate2;
   logic              bit_data;
   logic              bit_valid;
   logic              bit_ready;
   logic              multiplier_engaged;
   logic              reference_clock_input;
   logic              ref_ratio_ok;
   logic              symbol_underrun;
   logic signed [9:0] i_out;
   logic signed [9:0] q_out;
   logic              run;
   logic              rnd_bits;
   logic [3:0]        pattern;
   logic [2:0]        plen;
   int                accepted;
   int                errors;
   int                tests_run;
   int                ref_half;
   int                mag3;

   qid_datapath uut (.clk(clk), .rst_n(rst_n), .qam16_mode(qam16_mode), .rate1(rate1),
      .rate2(rate2), .bit_data(bit_data), .bit_valid(bit_valid), .bit_ready(bit_ready),
      .multiplier_engaged(multiplier_engaged), .reference_clock_input(reference_clock_input),
      .ref_ratio_ok(ref_ratio_ok), .symbol_underrun(symbol_underrun), .i_out(i_out),
      .q_out(q_out));

   qid_bit_source src (.clk(clk), .rst_n(rst_n), .run(run), .rnd_bits(rnd_bits),
      .pattern(pattern), .plen(plen), .bit_ready(bit_ready), .bit_valid(bit_valid),
      .bit_data(bit_data), .accepted(accepted));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // The reference pin runs free, a whole number of system clocks per half period.
   initial begin
      reference_clock_input = 1'b0;
      ref_half = 3;
      forever begin
         repeat (ref_half) @(posedge clk);
         #2 reference_clock_input = ~reference_clock_input;
      end
   end

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Ratios below the minimum are taken as the minimum by the design.
   function automatic int sym_period(input int r1, input int r2);
      return qid_pkg::UPSAMPLE * ((r1 < qid_pkg::R1_MIN) ? qid_pkg::R1_MIN : r1) *
             ((r2 < qid_pkg::R2_MIN) ? qid_pkg::R2_MIN : r2);
   endfunction

   function automatic int bits_per_sym(input logic mode);
      return mode ? qid_pkg::BITS_QAM16 : qid_pkg::BITS_QPSK;
   endfunction

   task automatic set_up(input logic mode, input int r1, input int r2, input logic rnd,
                         input logic [3:0] pat);
      @(posedge clk);
      #2;
      rst_n = 1'b0;
      qam16_mode = mode;
      rate1 = r1[4:0];
      rate2 = r2[5:0];
      rnd_bits = rnd;
      pattern = pat;
      plen = mode ? 3'h4 : 3'h2;
      repeat (3) @(posedge clk);
      #2;
      chk("reset_i", i_out, 32'h0);
      chk("reset_q", q_out, 32'h0);
      chk("reset_ready", bit_ready, 32'h1);
      chk("reset_underrun", symbol_underrun, 32'h0);
      chk("reset_ref", ref_ratio_ok, 32'h0);
      rst_n = 1'b1;
   endtask

   task automatic rate_case(input logic mode, input int r1, input int r2, input int cycles);
      int start;
      int got;
      int exp;
      set_up(mode, r1, r2, 1'b1, 4'h0);
      repeat (500) @(posedge clk);
      start = accepted;
      repeat (cycles) @(posedge clk);
      got = accepted - start;
      exp = bits_per_sym(mode) * cycles / sym_period(r1, r2);
      chk("bit_rate", (got >= exp - bits_per_sym(mode)) && (got <= exp + bits_per_sym(mode)),
          32'h1);
   endtask

   task automatic sign_case(input logic mode, input logic [3:0] pat, input logic i_neg,
                            input logic q_neg);
      set_up(mode, 3, 2, 1'b0, pat);
      repeat (1500) @(posedge clk);
      // The outputs are taken every clock as the carrier stage would; no carrier is modelled.
      repeat (8) begin
         @(posedge clk);
         #2;
         chk("i_sign", i_out[9], i_neg);
         chk("q_sign", q_out[9], q_neg);
         chk("i_live", i_out != 10'h000, 32'h1);
      end
   endtask

   initial begin
      rst_n = 1'b0;
      qam16_mode = 1'b0;
      rate1 = 5'h03;
      rate2 = 6'h02;
      run = 1'b1;
      rnd_bits = 1'b1;
      pattern = 4'h0;
      plen = 3'h2;
      multiplier_engaged = 1'b1;
      errors = 0;
      tests_run = 0;
      rate_case(1'b0, 3, 2, 2400);
      rate_case(1'b1, 5, 4, 2400);
      rate_case(1'b0, 1, 0, 2400);
      rate_case(1'b1, 10, 12, 4800);
      rate_case(1'b0, 31, 63, 23436);
      sign_case(1'b0, 4'h1, 1'b0, 1'b1);
      sign_case(1'b0, 4'h2, 1'b1, 1'b0);
      sign_case(1'b1, 4'h8, 1'b0, 1'b1);
      mag3 = i_out;
      sign_case(1'b1, 4'h7, 1'b1, 1'b0);
      chk("level_order", mag3 > -int'(i_out), 32'h1);
      sign_case(1'b0, 4'h0, 1'b0, 1'b0);
      chk("iq_same", i_out, q_out);
      run = 1'b0;
      repeat (5 * sym_period(3, 2)) @(posedge clk);
      #2;
      chk("underrun_set", symbol_underrun, 32'h1);
      run = 1'b1;
      repeat (3 * sym_period(3, 2)) @(posedge clk);
      #2;
      chk("underrun_clear", symbol_underrun, 32'h0);
      repeat (40) @(posedge clk);
      #2;
      chk("ref_six", ref_ratio_ok, 32'h1);
      ref_half = 4;
      repeat (40) @(posedge clk);
      #2;
      chk("ref_eight", ref_ratio_ok, 32'h0);
      ref_half = 3;
      multiplier_engaged = 1'b0;
      repeat (40) @(posedge clk);
      #2;
      chk("ref_off", ref_ratio_ok, 32'h0);
      multiplier_engaged = 1'b1;
      repeat (40) @(posedge clk);
      #2;
      chk("ref_on", ref_ratio_ok, 32'h1);
      report_and_stop();
   end

   // The whole sequence needs about 1.2 ms; two leaves room without hiding a hang.
   initial begin
      #2000000;
      errors++;
      report_and_stop();
   end
endmodule
